//--- hw/phy_timing_regs.svh
// Purpose: Timing constants of the path latency and carrier block
// Assumes: 100 MHz core clock
// Notes: Figures in bit times unless the name says otherwise
`ifndef PHY_TIMING_REGS_SVH
`define PHY_TIMING_REGS_SVH

`define CLK_PERIOD_NS 10
`define BIT_NS_100M 10
`define BIT_NS_10M 100
`define BIT_CYC_100M 4'((`BIT_NS_100M) / (`CLK_PERIOD_NS))
`define BIT_CYC_10M 4'((`BIT_NS_10M) / (`CLK_PERIOD_NS))
`define NIBBLE_BITS 2'd3
`define TX_LAT_100M 3'd4
`define TX_LAT_10M_MII 3'd1
`define TX_LAT_SERIAL 3'd1
`define LINE_DELAY_DEPTH 4
`define DELIM_BITS 5
`define DELIM_J 5'h18
`define DELIM_T 5'h0d
`define CRS_ON_BITS 11
`define CRS_OFF_BITS 15
`define COL_OFF_BITS 12
`define CRS_ON_WAIT 4'((`CRS_ON_BITS) - (`DELIM_BITS) - 1)
`define CRS_OFF_WAIT 4'((`CRS_OFF_BITS) - (`DELIM_BITS) - 1)
`define COL_OFF_WAIT 4'((`COL_OFF_BITS) - (`DELIM_BITS) - 1)
`define POR_MIN_MS 109
`define POR_MAX_MS 200
`define POR_MS 150
`define POR_WAIT_CYCLES ((`POR_MS) * 1000000 / (`CLK_PERIOD_NS))

`endif

//--- hw/phy_timing_pkg.sv
// Purpose: Types shared by the path latency and carrier block
// Assumes: Constants come from phy_timing_regs.svh
// Notes: Types only
package phy_timing_pkg;
	// Interface mode selected by straps
	typedef enum logic [1:0] {IF_MII, IF_STREAM, IF_SERIAL} if_mode_t;
	// One line bit with its presence flag
	typedef struct packed {
		logic valid;
		logic data;
	} line_bit_t;
	// Transmit request from the MAC side
	typedef struct packed {
		logic en;
		logic er;
		logic [3:0] data;
	} mac_tx_t;
	// Receive delimiter tracker
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_FRAME, RX_END} rx_state_t;
endpackage : phy_timing_pkg

//--- hw/bit_delay_line.sv
// Purpose: Short delay line of line bits with a selectable tap
// Assumes: shift is a one-cycle pulse per bit time
// Notes: Output comes from a register; tap counts whole bit times, 1..4
`timescale 1ns/10ps
`default_nettype none
`include "phy_timing_regs.svh"

module bit_delay_line import phy_timing_pkg::*; (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic shift,
	input wire logic [2:0] tap,
	input wire line_bit_t din,
	output line_bit_t dout
);
	line_bit_t stage_q [`LINE_DELAY_DEPTH]; // Bit history, newest first
	line_bit_t stage_d [`LINE_DELAY_DEPTH];
	line_bit_t dout_d;

	// Next values: move one place per bit time, pick the tap
	always_comb begin
		stage_d = stage_q;
		dout_d = dout;
		if (shift) begin
			stage_d[0] = din;
			for (int i = 1; i < `LINE_DELAY_DEPTH; i++) begin
				stage_d[i] = stage_q[i-1];
			end
			// Tap n: the bit leaves n whole bit times after it came in,
			// so the count starts at the capture tick itself
			if (tap <= 3'd1) begin
				dout_d = stage_q[0];
			end else begin
				dout_d = stage_q[tap[1:0] - 2'd1];
			end
		end
	end

	// Registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `LINE_DELAY_DEPTH; i++) begin
				stage_q[i] <= '0;
			end
			dout <= '0;
		end else begin
			stage_q <= stage_d;
			dout <= dout_d;
		end
	end
endmodule : bit_delay_line

`default_nettype wire

//--- hw/phy_path_timing.sv
// Purpose: Transmit and receive path latency, carrier and collision
// Assumes: One 100 MHz clock; all pins synchronised here
// Notes: Line is modelled as one bit per bit time, no coding
`timescale 1ns/10ps
`default_nettype none
`include "phy_timing_regs.svh"

module phy_path_timing import phy_timing_pkg::*; #(
	parameter int unsigned POR_CYCLES = `POR_WAIT_CYCLES
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic speed_100,
	input wire logic full_duplex,
	input wire logic [1:0] if_mode,
	input wire logic mii_tx_en,
	input wire logic mii_tx_er,
	input wire logic [3:0] mii_txd,
	input wire logic serial_tx_data,
	input wire logic serial_tx_enable,
	input wire logic line_receive_pair,
	output logic tx_clock,
	output logic serial_tx_clock,
	output logic rx_clock,
	output logic [3:0] rxd,
	output logic rx_dv,
	output logic crs,
	output logic col,
	output logic line_transmit_pair,
	output logic line_transmit_enable,
	output logic reset_done
);
	// Every pin goes through two flops; only sync2_q is read
	logic [14:0] sync1_q, sync2_q;
	mac_tx_t mac_tx;
	if_mode_t mode;
	logic fast, fdx, ser_en, ser_bit, line_in;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {speed_100, full_duplex, if_mode, mii_tx_en, mii_tx_er,
				mii_txd, serial_tx_data, serial_tx_enable, line_receive_pair,
				2'b00};
			sync2_q <= sync1_q;
		end
	end

	assign fast = sync2_q[14];
	assign fdx = sync2_q[13];
	assign mode = (sync2_q[12:11] == 2'b11) ? IF_MII : if_mode_t'(sync2_q[12:11]);
	assign mac_tx = mac_tx_t'(sync2_q[10:5]);
	assign ser_bit = sync2_q[4];
	assign ser_en = sync2_q[3];
	assign line_in = sync2_q[2];

	// Power-on wait: clocks stay quiet until the count is done
	logic [27:0] por_cnt_q, por_cnt_d;
	logic reset_done_d;

	always_comb begin
		por_cnt_d = por_cnt_q;
		reset_done_d = reset_done;
		if (!reset_done) begin
			if (por_cnt_q == 28'(POR_CYCLES - 1)) begin
				reset_done_d = 1'b1;
			end else begin
				por_cnt_d = por_cnt_q + 28'h1;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			por_cnt_q <= '0;
			reset_done <= 1'b0;
		end else begin
			por_cnt_q <= por_cnt_d;
			reset_done <= reset_done_d;
		end
	end

	// Timebase: one bit tick per line bit of the active speed
	logic serial;
	logic [3:0] cyc_q, cyc_d, bit_cyc;
	logic [1:0] nib_q, nib_d;
	logic bit_tick, capture, tx_clock_d, serial_tx_clock_d;

	assign serial = (mode == IF_SERIAL);
	// Serial interface only exists at 10M
	assign bit_cyc = (fast && !serial) ? `BIT_CYC_100M : `BIT_CYC_10M;
	assign bit_tick = reset_done && (cyc_q == bit_cyc - 4'h1);
	// Capture edge: start of each nibble, or each bit in serial mode
	assign capture = bit_tick && (serial || nib_q == `NIBBLE_BITS);

	always_comb begin
		cyc_d = bit_tick ? 4'h0 : (reset_done ? cyc_q + 4'h1 : 4'h0);
		nib_d = bit_tick ? nib_q + 2'h1 : nib_q;
		// Clock goes high on the capture edge and stays half a period
		tx_clock_d = reset_done && !serial && (nib_d < 2'd2);
		serial_tx_clock_d = reset_done && serial && (cyc_d < (bit_cyc >> 1));
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cyc_q <= '0;
			nib_q <= '0;
			tx_clock <= 1'b0;
			serial_tx_clock <= 1'b0;
		end else begin
			cyc_q <= cyc_d;
			nib_q <= nib_d;
			tx_clock <= tx_clock_d;
			serial_tx_clock <= serial_tx_clock_d;
		end
	end

	// Receive clock runs with the transmit clock from the same divider
	assign rx_clock = tx_clock;

	// Transmit: serialise the captured nibble, then delay to the line
	logic [3:0] ser_q, ser_d;
	logic [1:0] left_q, left_d;
	logic tx_act_q, tx_act_d;
	line_bit_t tx_bit, line_bit;
	logic [2:0] tap;

	always_comb begin
		ser_d = ser_q;
		left_d = left_q;
		tx_act_d = tx_act_q;
		tx_bit = '0;
		if (capture) begin
			// Carrier from our own send follows the sampled enable
			tx_act_d = serial ? ser_en : mac_tx.en;
			if (serial && ser_en) begin
				tx_bit = '{valid: 1'b1, data: ser_bit};
			end else if (!serial && mac_tx.en) begin
				// First bit leaves on the capture tick itself
				tx_bit = '{valid: 1'b1, data: mac_tx.data[0]};
				ser_d = {1'b0, mac_tx.data[3:1]};
				left_d = 2'd3;
			end else begin
				left_d = 2'd0;
			end
		end else if (bit_tick && left_q != 2'd0) begin
			tx_bit = '{valid: 1'b1, data: ser_q[0]};
			ser_d = {1'b0, ser_q[3:1]};
			left_d = left_q - 2'd1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ser_q <= '0;
			left_q <= '0;
			tx_act_q <= 1'b0;
		end else begin
			ser_q <= ser_d;
			left_q <= left_d;
			tx_act_q <= tx_act_d;
		end
	end

	// Line delay chosen per mode; 100M sends exactly four bits late
	always_comb begin
		if (serial) begin
			tap = `TX_LAT_SERIAL;
		end else if (fast) begin
			tap = `TX_LAT_100M;
		end else begin
			tap = `TX_LAT_10M_MII;
		end
	end

	bit_delay_line u_tx_delay (
		.clock(clock),
		.arst_n(arst_n),
		.shift(bit_tick),
		.tap(tap),
		.din(tx_bit),
		.dout(line_bit)
	);

	assign line_transmit_pair = line_bit.data;
	assign line_transmit_enable = line_bit.valid;

	// Receive: five-bit history, delimiter tracking, carrier timing
	logic [4:0] hist_q, hist_d;
	rx_state_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d, rxd_d;
	logic rx_crs_q, rx_crs_d, col_q, col_d, rx_dv_d;

	always_comb begin
		hist_d = bit_tick ? {hist_q[3:0], line_in} : hist_q;
		st_d = st_q;
		cnt_d = cnt_q;
		rx_crs_d = rx_crs_q;
		col_d = col_q;
		case (st_q)
			RX_IDLE: begin
				if (bit_tick && hist_d == `DELIM_J) begin
					st_d = RX_START;
					cnt_d = 4'h0;
				end
			end
			RX_START: begin
				if (bit_tick) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == `CRS_ON_WAIT) begin
						st_d = RX_FRAME;
						rx_crs_d = 1'b1;
						col_d = tx_act_q && !fdx;
					end
				end
			end
			RX_FRAME: begin
				// Our own send starting mid-frame is a collision too
				col_d = tx_act_q && !fdx;
				if (bit_tick && hist_d == `DELIM_T) begin
					st_d = RX_END;
					cnt_d = 4'h0;
				end
			end
			RX_END: begin
				if (bit_tick) begin
					cnt_d = cnt_q + 4'h1;
					if (cnt_q == `COL_OFF_WAIT) begin
						col_d = 1'b0;
					end
					if (cnt_q == `CRS_OFF_WAIT) begin
						st_d = RX_IDLE;
						rx_crs_d = 1'b0;
					end
				end
			end
			default: begin
				st_d = RX_IDLE;
			end
		endcase
		// Nibble handed out at the receive clock edge; the start
		// delimiter is handed out on the tick that completes it, since
		// waiting for the next nibble edge would blow the latency budget
		if (capture || (st_q == RX_IDLE && st_d == RX_START)) begin
			rxd_d = hist_d[3:0];
			rx_dv_d = (st_d != RX_IDLE);
		end else begin
			rxd_d = rxd;
			rx_dv_d = rx_dv;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hist_q <= '0;
			st_q <= RX_IDLE;
			cnt_q <= '0;
			rx_crs_q <= 1'b0;
			col_q <= 1'b0;
			rxd <= '0;
			rx_dv <= 1'b0;
		end else begin
			hist_q <= hist_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			rx_crs_q <= rx_crs_d;
			col_q <= col_d;
			rxd <= rxd_d;
			rx_dv <= rx_dv_d;
		end
	end

	// Own send only raises carrier in half duplex
	assign crs = rx_crs_q || (!fdx && tx_act_q);
	assign col = col_q && !fdx;

	// Checks
	logic [4:0] since_j_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			since_j_q <= '0;
		end else if (st_q == RX_IDLE) begin
			since_j_q <= '0;
		end else if (bit_tick && since_j_q != 5'h1f) begin
			since_j_q <= since_j_q + 5'h1;
		end
	end

	carrier_on_tx_a: assert property (@(posedge clock) disable iff (!arst_n)
		capture && !serial && mac_tx.en && !fdx |=> crs)
		else $error("carrier late after send start");
	carrier_off_tx_a: assert property (@(posedge clock) disable iff (!arst_n)
		capture && !serial && !mac_tx.en && !fdx && !rx_crs_q && !rx_crs_d
		|=> !crs)
		else $error("carrier late after send end");
	fast_tx_lat_a: assert property (@(posedge clock) disable iff (!arst_n)
		capture && fast && !serial && mac_tx.en && !tx_act_q
		|-> ##5 $rose(line_transmit_enable))
		else $error("100M send latency not four bits");
	serial_tx_lat_a: assert property (@(posedge clock) disable iff (!arst_n)
		capture && serial && ser_en |-> ##[1:20] line_transmit_enable)
		else $error("serial bit late on line");
	crs_rx_on_a: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(rx_crs_q) |-> since_j_q >= 5'd4 && since_j_q <= 5'd8)
		else $error("receive carrier outside window");
	col_on_a: assert property (@(posedge clock) disable iff (!arst_n)
		$rose(col) |-> st_q == RX_FRAME && tx_act_q)
		else $error("collision without overlap");
	crs_rx_off_a: assert property (@(posedge clock) disable iff (!arst_n)
		$fell(rx_crs_q) |-> $past(st_q) == RX_END && $past(cnt_q) == `CRS_OFF_WAIT)
		else $error("receive carrier dropped at wrong time");
	col_before_crs_a: assert property (@(posedge clock) disable iff (!arst_n)
		st_q == RX_IDLE |-> !col_q)
		else $error("collision outlives end window");
	por_quiet_a: assert property (@(posedge clock) disable iff (!arst_n)
		!reset_done |-> !tx_clock && !serial_tx_clock && !line_transmit_enable)
		else $error("clock before power-on wait done");
endmodule : phy_path_timing

`default_nettype wire

//--- verification/mac_model.sv
// Purpose: MAC side model driving the transmit nibble pins
// Assumes: Nibbles change one step after each transmit clock rise
// Notes: Notes every line bit it expects, first sent first
`timescale 1ns/10ps
`default_nettype none

module mac_model (
	input wire logic tx_clock,
	input wire logic send,
	output logic mii_tx_en,
	output logic [3:0] mii_txd
);
	int seed = 69141; // Fixed seed for nibble values
	logic exp_q[$]; // Expected line bits
	initial begin
		mii_tx_en = 1'b0;
		mii_txd = 4'h0;
	end
	// Change after the rise and hold a whole nibble period for setup
	always @(posedge tx_clock) begin
		#1;
		mii_tx_en = send;
		// Idle data toggles so a stale nibble never looks good
		mii_txd = send ? 4'($random(seed)) : ~mii_txd;
		for (int i = 0; i < 4; i++) begin
			if (send) exp_q.push_back(mii_txd[i]);
		end
	end
endmodule : mac_model

`default_nettype wire

//--- verification/phy_path_latency_carrier_timing_test.sv
// Purpose: Self-checking bench of path latency and carrier timing
// Assumes: Short power-on count; line carries one bit per bit time
// Notes: Latencies counted in clock edges; bc edges make one bit
`timescale 1ns/10ps
`default_nettype none

module phy_path_latency_carrier_timing_test import phy_timing_pkg::*;;
	localparam int POR_C = 20; // Short power-on wait
	localparam bit SP [3] = '{1'b1, 1'b1, 1'b0}; // Speed per pass
	localparam logic [1:0] MD [3] = '{2'h0, 2'h1, 2'h0}; // Mode per pass
	localparam int DV [3] = '{17, 12, 90}; // Data valid limit, edges
	logic clock = 1'b0, arst_n = 1'b0, speed_100 = 1'b1;
	logic full_duplex = 1'b0, mii_tx_er = 1'b0, send = 1'b0;
	logic [1:0] if_mode = 2'h0;
	logic serial_tx_data = 1'b0, serial_tx_enable = 1'b0;
	logic line_receive_pair = 1'b0, mii_tx_en, tx_clock, serial_tx_clock;
	logic rx_clock, rx_dv, crs, col, reset_done;
	logic line_transmit_pair, line_transmit_enable;
	logic [3:0] mii_txd, rxd;
	int seed = 69141, err_count = 0, checks_done = 0, bc = 1, ph = 0;
	int n0, n1; // Measured latencies

	always #5 clock = ~clock;

	mac_model mac (.tx_clock(tx_clock), .send(send),
		.mii_tx_en(mii_tx_en), .mii_txd(mii_txd));

	phy_path_timing #(.POR_CYCLES(POR_C)) dut (.clock(clock),
		.arst_n(arst_n), .speed_100(speed_100), .full_duplex(full_duplex),
		.if_mode(if_mode), .mii_tx_en(mii_tx_en), .mii_tx_er(mii_tx_er),
		.mii_txd(mii_txd), .serial_tx_data(serial_tx_data),
		.serial_tx_enable(serial_tx_enable),
		.line_receive_pair(line_receive_pair), .tx_clock(tx_clock),
		.serial_tx_clock(serial_tx_clock), .rx_clock(rx_clock), .rxd(rxd),
		.rx_dv(rx_dv), .crs(crs), .col(col),
		.line_transmit_pair(line_transmit_pair),
		.line_transmit_enable(line_transmit_enable),
		.reset_done(reset_done));

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic give_verdict;
		$display("Checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	function automatic logic sig(input int sel);
		case (sel)
			0: return crs;
			1: return col;
			2: return line_transmit_enable;
			3: return reset_done;
			default: return rx_dv;
		endcase
	endfunction : sig

	// Edges until an output reaches a level; bounded so a miss is seen
	task automatic lat(input int sel, input logic lvl, output int n);
		n = 0;
		while (n < 400 && sig(sel) !== lvl) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask : lat

	// Drive line bits, first bit is the top one of the count
	task automatic line_bits(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			line_receive_pair = v[i];
			repeat (bc) @(posedge clock);
			#1;
		end
	endtask : line_bits

	// Reset, straps, and the power-on wait before any clock
	task automatic do_reset(input logic s, input logic [1:0] m);
		int n;
		arst_n = 1'b0;
		speed_100 = s;
		if_mode = m;
		bc = s ? 1 : 10;
		mac.exp_q.delete();
		repeat (8) @(posedge clock);
		#1;
		arst_n = 1'b1;
		lat(3, 1'b1, n);
		chk(n >= POR_C - 1 && n <= POR_C + 1, 1, "por_wait");
	endtask : do_reset

	// All expected line bits must leave within a bounded time
	task automatic drain;
		for (int i = 0; i < 60 * bc && mac.exp_q.size() > 0; i++) begin
			@(posedge clock);
		end
		#1;
		chk(mac.exp_q.size(), 0, "bits_left");
	endtask : drain

	// One compare per bit time while the line is driven
	always @(posedge clock) begin
		if (line_transmit_enable === 1'b1) begin
			if (ph == 0 && mac.exp_q.size() == 0) begin
				chk(1, 0, "extra_bit");
			end else if (ph == 0) begin
				chk(line_transmit_pair, mac.exp_q.pop_front(), "bit");
			end
			ph = (ph + 1 == bc) ? 0 : ph + 1;
		end else begin
			ph = 0;
		end
	end

	initial begin
		for (int c = 0; c < 3; c++) begin
			do_reset(SP[c], MD[c]);
			// Own send: carrier on, first line bit latency
			@(posedge tx_clock);
			send = 1'b1;
			@(posedge mii_tx_en);
			@(posedge tx_clock);
			#1;
			chk(crs, 1'b1, "crs_tx_on");
			lat(2, 1'b1, n0);
			if (SP[c]) chk(n0, 4, "tx_lat_100");
			else chk(n0 <= 19, 1, "tx_lat_10");
			repeat (3) @(posedge tx_clock);
			send = 1'b0;
			@(negedge mii_tx_en);
			fork
				lat(0, 1'b0, n0);
				begin
					@(posedge tx_clock);
					#1;
					chk(crs, 1'b0, "crs_tx_off");
				end
			join
			chk(n0 <= 4 * bc, 1, "crs_fall");
			drain;
			// Received frame: start then end delimiter
			fork
				line_bits({5'b11000, 15'h7fff}, 20);
				lat(0, 1'b1, n0);
				lat(4, 1'b1, n1);
			join
			chk(n0 > 9 * bc && n0 <= 13 * bc, 1, "crs_rx_on");
			chk(n1 <= DV[c], 1, "rx_dv_on");
			fork
				line_bits({5'b01101, 20'h0}, 25);
				lat(0, 1'b0, n0);
			join
			chk(n0 > 13 * bc && n0 <= 17 * bc, 1, "crs_rx_off");
			// Delimiter arriving while sending raises collision
			@(posedge tx_clock);
			send = 1'b1;
			@(posedge line_transmit_enable);
			#1;
			fork
				line_bits({5'b11000, 15'h7fff}, 20);
				lat(1, 1'b1, n0);
			join
			chk(n0 > 9 * bc && n0 <= 13 * bc, 1, "col_on");
			// Keep sending through the end delimiter so only the timer
			// can clear the collision
			fork
				line_bits({5'b01101, 20'h0}, 25);
				lat(1, 1'b0, n0);
			join
			chk(n0 > 0 && n0 <= 14 * bc, 1, "col_off");
			@(posedge tx_clock);
			send = 1'b0;
			drain;
		end
		// Serial mode: one random bit per serial clock
		do_reset(1'b0, 2'h2);
		@(posedge serial_tx_clock);
		#1;
		fork
			for (int i = 0; i < 9; i++) begin
				serial_tx_enable = (i < 8);
				serial_tx_data = 1'($random(seed));
				if (i < 8) mac.exp_q.push_back(serial_tx_data);
				@(posedge serial_tx_clock);
				#1;
			end
			begin
				@(posedge serial_tx_clock);
				#1;
				lat(2, 1'b1, n0);
			end
		join
		chk(n0 <= 19, 1, "serial_lat");
		drain;
		give_verdict;
	end

	// Watchdog far beyond the expected run length
	initial begin
		#500000;
		err_count++;
		give_verdict;
	end
endmodule : phy_path_latency_carrier_timing_test

`default_nettype wire
